// ### verilog/wdat_pkg.sv
// Purpose: constants and types for the watchdog and address trap
// Assumes: clk_sys_i is the high-frequency clock
// Notes: registers are write-only byte registers
`default_nettype none

package wdat_pkg;

	// ***************************************
	// register map
	// ***************************************
	localparam logic [7:0] WDAT_CTRL_ADDR = 8'h34;
	localparam logic [7:0] WDAT_CODE_ADDR = 8'h35;
	localparam logic [7:0] WDAT_READ_VAL = 8'h00;

	// ***************************************
	// control register fields
	// ***************************************
	localparam int WDAT_BIT_RAMTRAP = 5;
	localparam int WDAT_BIT_TRAPACT = 4;
	localparam int WDAT_BIT_RUN = 3;
	localparam int WDAT_BIT_DT_HI = 2;
	localparam int WDAT_BIT_DT_LO = 1;
	localparam int WDAT_BIT_OVF = 0;

	localparam logic WDAT_RST_RAMTRAP = 1'b1;
	localparam logic WDAT_RST_TRAPACT = 1'b1;
	localparam logic WDAT_RST_RUN = 1'b1;
	localparam logic [1:0] WDAT_RST_DT = 2'h0;
	localparam logic WDAT_RST_OVF = 1'b1;

	// ***************************************
	// code port values
	// ***************************************
	localparam logic [7:0] WDAT_CODE_CLEAR = 8'h4e;
	localparam logic [7:0] WDAT_CODE_DISABLE = 8'hb1;
	localparam logic [7:0] WDAT_CODE_TRAPARM = 8'hd2;

	// ***************************************
	// counter and timing
	// ***************************************
	localparam logic [1:0] WDAT_BIN_MAX = 2'h3;
	localparam logic [1:0] WDAT_BIN_ZERO = 2'h0;
	localparam int WDAT_FC_DIV_EXP = 23;
	localparam int WDAT_FS_DIV_EXP = 15;
	localparam int WDAT_DT_STEP = 2;
	localparam int WDAT_CLK_PERIOD_NS = 50;
	localparam int WDAT_HFC_PERIOD_NS = 50;
	localparam int WDAT_RST_TIME_FC = 24;
	localparam int WDAT_RST_CYC =
		(WDAT_RST_TIME_FC * WDAT_HFC_PERIOD_NS) / WDAT_CLK_PERIOD_NS;
	localparam int WDAT_RST_CNT_W = 5;

	// ***************************************
	// types
	// ***************************************
	typedef struct packed {
		logic valid;
		logic ram;
		logic special_function_area;
		logic data_buffer_area;
	} wdat_fetch_s;

	typedef enum logic {
		WDAT_RS_IDLE,
		WDAT_RS_HOLD
	} wdat_rst_state_e;

endpackage

`default_nettype wire

// ### verilog/wdat_rst_stretch.sv
// Purpose: stretches a reset request to a bounded pulse
// Assumes: req_i is a one-cycle pulse
// Notes: a request during the pulse is ignored
`timescale 1ns/1ps
`default_nettype none

module wdat_rst_stretch
	import wdat_pkg::*;
#(
	parameter int CYC = WDAT_RST_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// request and pulse
	input wire logic req_i,
	output logic rst_o
);

	localparam logic [WDAT_RST_CNT_W-1:0] LAST =
		WDAT_RST_CNT_W'(CYC - 1);
	localparam logic [WDAT_RST_CNT_W-1:0] ONE =
		WDAT_RST_CNT_W'(1);
	localparam logic [WDAT_RST_CNT_W-1:0] ZERO =
		WDAT_RST_CNT_W'(0);

	wdat_rst_state_e state_q;
	logic [WDAT_RST_CNT_W-1:0] cnt_q;

	// pulse length never exceeds CYC cycles
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= WDAT_RS_IDLE;
			cnt_q <= ZERO;
		end else begin
			unique case (state_q)
				WDAT_RS_IDLE: begin
					if (req_i) begin
						state_q <= WDAT_RS_HOLD;
						cnt_q <= LAST;
					end
				end
				WDAT_RS_HOLD: begin
					if (cnt_q == ZERO) begin
						state_q <= WDAT_RS_IDLE;
					end else begin
						cnt_q <= cnt_q - ONE;
					end
				end
			endcase
		end
	end

	assign rst_o = (state_q == WDAT_RS_HOLD);

endmodule

`default_nettype wire

// ### verilog/wdat_top.sv
// Purpose: watchdog timer with instruction fetch address trap
// Assumes: clk_sys_i is the high-frequency clock, fs comes as ticks
// Notes: the cpu handles nmi nesting; this block only requests
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module wdat_top
	import wdat_pkg::*;
#(
	parameter int FC_DIV_EXP = WDAT_FC_DIV_EXP,
	parameter int FS_DIV_EXP = WDAT_FS_DIV_EXP,
	parameter int RST_CYC = WDAT_RST_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,

	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,

	// clock source and power mode
	input wire logic lfclk_tick_i,
	input wire logic prescale_source_select_i,
	input wire logic slow_mode_i,
	input wire logic slow1_mode_i,
	input wire logic lowpower_hold_i,

	// instruction fetch monitor
	input wire wdat_fetch_s fetch_i,

	// requests to the cpu and reset logic
	output logic watchdog_nmi_o,
	output logic trap_nmi_o,
	output logic internal_reset_o,
	output logic hfosc_restart_o,

	// status
	output logic wdt_running_o,
	output logic [1:0] bin_count_o,
	output logic ram_trap_active_o
);

	// ***************************************
	// register decode
	// ***************************************
	logic wr_ctrl;
	logic wr_code;
	logic code_clear;
	logic code_disable;
	logic code_traparm;

	assign wr_ctrl = wr_i && (addr_i == WDAT_CTRL_ADDR);
	assign wr_code = wr_i && (addr_i == WDAT_CODE_ADDR);
	// any other code value is ignored
	assign code_clear = wr_code &&
		(wdata_i == WDAT_CODE_CLEAR);
	assign code_disable = wr_code &&
		(wdata_i == WDAT_CODE_DISABLE);
	assign code_traparm = wr_code &&
		(wdata_i == WDAT_CODE_TRAPARM);

	// ***************************************
	// internal reset feedback
	// ***************************************
	logic rst_req;
	logic soft_rst;

	// the internal reset also reinitialises control, trap and counter state, not the divider
	assign soft_rst = internal_reset_o;

	// ***************************************
	// control register
	// ***************************************
	logic run_en_q;
	logic [1:0] dt_sel_q;
	logic ovf_act_q;
	logic trap_act_q;
	logic ram_trap_new_q;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			run_en_q <= WDAT_RST_RUN;
			dt_sel_q <= WDAT_RST_DT;
			trap_act_q <= WDAT_RST_TRAPACT;
			ram_trap_new_q <= WDAT_RST_RAMTRAP;
		end else if (soft_rst) begin
			run_en_q <= WDAT_RST_RUN;
			dt_sel_q <= WDAT_RST_DT;
			trap_act_q <= WDAT_RST_TRAPACT;
			ram_trap_new_q <= WDAT_RST_RAMTRAP;
		end else if (wr_ctrl) begin
			run_en_q <= wdata_i[WDAT_BIT_RUN];
			dt_sel_q <= wdata_i[WDAT_BIT_DT_HI:WDAT_BIT_DT_LO];
			trap_act_q <= wdata_i[WDAT_BIT_TRAPACT];
			ram_trap_new_q <= wdata_i[WDAT_BIT_RAMTRAP];
		end
	end

	// once cleared, the overflow action stays at interrupt until an internal or power-on reset
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ovf_act_q <= WDAT_RST_OVF;
		end else if (soft_rst) begin
			ovf_act_q <= WDAT_RST_OVF;
		end else if (wr_ctrl) begin
			ovf_act_q <= ovf_act_q &
				wdata_i[WDAT_BIT_OVF];
		end
	end

	// ***************************************
	// ram trap selection takes effect on arm code
	// ***************************************
	logic ram_trap_q;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ram_trap_q <= WDAT_RST_RAMTRAP;
		end else if (soft_rst) begin
			ram_trap_q <= WDAT_RST_RAMTRAP;
		end else if (code_traparm) begin
			ram_trap_q <= ram_trap_new_q;
		end
	end

	// ***************************************
	// watchdog run state
	// ***************************************
	logic running_q;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			running_q <= WDAT_RST_RUN;
		end else if (soft_rst) begin
			running_q <= WDAT_RST_RUN;
		end else if (wr_ctrl && wdata_i[WDAT_BIT_RUN]) begin
			running_q <= 1'b1;
		end else if (code_disable && !run_en_q) begin
			running_q <= 1'b0;
		end
	end

	// ***************************************
	// free-running divider
	// ***************************************
	logic src_fs;
	logic div_step;
	logic [FC_DIV_EXP-1:0] div_q;

	assign src_fs = prescale_source_select_i || slow_mode_i;
	// divider and counter both stand still while held
	assign div_step = !lowpower_hold_i &&
		(src_fs ? lfclk_tick_i : 1'b1);

	// never cleared by the code port, only by power-on reset
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_q <= '0;
		end else if (div_step) begin
			div_q <= div_q + 1'b1;
		end
	end

	// ***************************************
	// tap selection guard
	// ***************************************
	logic [2:0] tap_sel;
	logic [2:0] tap_sel_q;
	logic tap_sel_same;

	// a new source or detect time swaps the tap bit under the
	// edge detector; that cycle must not count as a fall
	assign tap_sel = {src_fs, dt_sel_q};
	assign tap_sel_same = (tap_sel == tap_sel_q);

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tap_sel_q <= {1'b0, WDAT_RST_DT};
		end else begin
			tap_sel_q <= tap_sel;
		end
	end

	// ***************************************
	// detection time tap
	// ***************************************
	localparam int DT_CODES = 4;

	logic [DT_CODES-1:0] tap_fc;
	logic [DT_CODES-1:0] tap_fs;
	logic tap;
	logic tap_q;
	logic bin_tick;

	// one candidate tap per detect time code and clock source;
	// a code whose bit lies outside the divider reads as zero
	for (genvar g = 0; g < DT_CODES; g++) begin : g_tap
		localparam int IDX_FC = FC_DIV_EXP - 1 - WDAT_DT_STEP * g;
		localparam int IDX_FS = FS_DIV_EXP - 1 - WDAT_DT_STEP * g;
		if (IDX_FC >= 0) begin : g_fc
			assign tap_fc[g] = div_q[IDX_FC];
		end else begin : g_fc_none
			assign tap_fc[g] = 1'b0;
		end
		if (IDX_FS >= 0 && IDX_FS < FC_DIV_EXP) begin : g_fs
			assign tap_fs[g] = div_q[IDX_FS];
		end else begin : g_fs_none
			assign tap_fs[g] = 1'b0;
		end
	end

	// four periods of the selected tap make one detection time
	assign tap = src_fs ? tap_fs[dt_sel_q] : tap_fc[dt_sel_q];

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tap_q <= 1'b0;
		end else begin
			tap_q <= tap;
		end
	end

	// falling edge of the tap advances the binary counter
	assign bin_tick = tap_q && !tap && tap_sel_same &&
		!lowpower_hold_i;

	// ***************************************
	// two-stage binary counter
	// ***************************************
	logic [1:0] bin_q;
	logic overflow;

	// divider phase persists, so the first overflow after a
	// clear may come after only three of four periods; a clear
	// in the same cycle wins, and nothing overflows in reset
	assign overflow = running_q && bin_tick && !code_clear &&
		!soft_rst && (bin_q == WDAT_BIN_MAX);

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bin_q <= WDAT_BIN_ZERO;
		end else if (soft_rst || !running_q) begin
			bin_q <= WDAT_BIN_ZERO;
		end else if (code_clear) begin
			bin_q <= WDAT_BIN_ZERO;
		end else if (bin_tick) begin
			bin_q <= bin_q + 2'h1;
		end
	end

	// ***************************************
	// address trap detect
	// ***************************************
	logic trap_hit;

	// special function and buffer areas trap regardless
	assign trap_hit = fetch_i.valid && !soft_rst &&
		(fetch_i.special_function_area || fetch_i.data_buffer_area ||
		(fetch_i.ram && ram_trap_q));

	// ***************************************
	// request routing
	// ***************************************
	logic wdt_rst;
	logic wdt_int;
	logic trap_rst;
	logic trap_int;

	assign wdt_rst = overflow && ovf_act_q;
	assign wdt_int = overflow && !ovf_act_q;
	assign trap_rst = trap_hit && trap_act_q;
	assign trap_int = trap_hit && !trap_act_q;
	assign rst_req = wdt_rst || trap_rst;

	// ***************************************
	// nmi outputs
	// ***************************************
	// one pulse per event, never gated by the master flag or
	// by an interrupt already in service
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			watchdog_nmi_o <= 1'b0;
		end else begin
			watchdog_nmi_o <= wdt_int;
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			trap_nmi_o <= 1'b0;
		end else begin
			trap_nmi_o <= trap_int;
		end
	end

	// ***************************************
	// internal reset pulse
	// ***************************************
	wdat_rst_stretch #(
		.CYC(RST_CYC)
	) u_rst (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.req_i(rst_req),
		.rst_o(internal_reset_o)
	);

	// oscillator restart is requested with a reset in slow1
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hfosc_restart_o <= 1'b0;
		end else begin
			hfosc_restart_o <= rst_req &&
				slow1_mode_i;
		end
	end

	// ***************************************
	// read path
	// ***************************************
	// both registers are write-only; reads give a fixed value
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= WDAT_READ_VAL;
		end else if (rd_i) begin
			rdata_o <= WDAT_READ_VAL;
		end
	end

	// ***************************************
	// status outputs
	// ***************************************
	assign wdt_running_o = running_q;
	assign bin_count_o = bin_q;
	assign ram_trap_active_o = ram_trap_q;

endmodule

`default_nettype wire

// ### tb/wdat_checker.sv
// Purpose: port assertions for the watchdog and trap block
// Assumes: one clock domain, async active-low reset
// Notes: bound into wdat_top
`timescale 1ns/1ps
`default_nettype none

module wdat_checker
	import wdat_pkg::*;
#(
	parameter int RST_CYC = WDAT_RST_CYC
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// mode and fetch
	input wire logic lowpower_hold_i,
	input wire wdat_fetch_s fetch_i,
	// outputs
	input wire logic watchdog_nmi_o,
	input wire logic trap_nmi_o,
	input wire logic internal_reset_o,
	input wire logic wdt_running_o,
	input wire logic [1:0] bin_count_o,
	input wire logic ram_trap_active_o
);
	// ****
	// helpers
	// ****
	logic code_wr;
	logic [7:0] cyc_q;
	assign code_wr = wr_i && addr_i == WDAT_CODE_ADDR;
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i)
			cyc_q <= 8'h00;
		else
			cyc_q <= internal_reset_o ? cyc_q + 8'h01 : 8'h00;
	end
	default clocking dcb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);
	// ****
	// assertions
	// ****
	a_clear_count: assert property (
		code_wr && wdata_i == WDAT_CODE_CLEAR |=> bin_count_o == WDAT_BIN_ZERO)
		else $error("clear code ignored");
	a_nmi_pulse: assert property (
		watchdog_nmi_o |=> !watchdog_nmi_o) else $error("nmi too long");
	a_hold_freezes_count: assert property (
		lowpower_hold_i && !wr_i && !fetch_i.valid && !internal_reset_o
		|=> $stable(bin_count_o)) else $error("count moved in hold");
	a_disabled_count_zero: assert property (
		!wdt_running_o ##1 !wdt_running_o |-> bin_count_o == WDAT_BIN_ZERO)
		else $error("count nonzero while off");
	a_disable_by_code: assert property (
		$fell(wdt_running_o) |-> $past(code_wr && wdata_i == WDAT_CODE_DISABLE))
		else $error("stopped without code");
	a_arm_by_code: assert property (
		$fell(ram_trap_active_o)
		|-> $past(code_wr && wdata_i == WDAT_CODE_TRAPARM))
		else $error("ram trap changed without code");
	a_fetch_traps: assert property (
		fetch_i.valid && (fetch_i.special_function_area || fetch_i.data_buffer_area) && !internal_reset_o
		|=> trap_nmi_o || internal_reset_o) else $error("fetch not trapped");
	a_trap_cause: assert property (
		trap_nmi_o |-> $past(fetch_i.valid && (fetch_i.special_function_area || fetch_i.data_buffer_area
		|| fetch_i.ram && ram_trap_active_o))) else $error("stray trap");
	a_reset_length: assert property (
		$fell(internal_reset_o) |-> cyc_q == 8'(RST_CYC))
		else $error("reset pulse length wrong");
	a_read_value: assert property (
		rd_i |=> rdata_o == WDAT_READ_VAL) else $error("read value wrong");
	c_wnmi: cover property (watchdog_nmi_o);
	c_tnmi: cover property (trap_nmi_o);
	c_rst: cover property ($fell(internal_reset_o));
endmodule

bind wdat_top wdat_checker #(.RST_CYC(RST_CYC)) u_chk (.clk_sys_i,
	.arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .lowpower_hold_i,
	.fetch_i, .watchdog_nmi_o, .trap_nmi_o, .internal_reset_o,
	.wdt_running_o, .bin_count_o, .ram_trap_active_o);

`default_nettype wire

// ### tb/wdat_top_test.sv
// Purpose: directed bench for the watchdog and trap block
// Assumes: divider exponents shortened to 6 and 4
// Notes: output pulses are counted on the falling edge
`timescale 1ns/1ps
`default_nettype none

module wdat_top_test
	import wdat_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic lfclk_tick_i = 1'b0;
	logic pss = 1'b0;
	logic slow = 1'b0;
	logic slow1 = 1'b0;
	logic hold = 1'b0;
	wdat_fetch_s fetch_i = '0;
	logic [7:0] rdata_o;
	logic wnmi, tnmi, irst, hfr, run, ram_act, ir_q;
	logic [1:0] bcnt;
	logic [1:0] lf = 2'h0;
	logic [7:0] n_wn = 8'h00;
	logic [7:0] n_tn = 8'h00;
	logic [7:0] n_ir = 8'h00;
	logic [7:0] n_hf = 8'h00;
	logic [7:0] s;
	int n_fail = 0;
	int num_checks = 0;

	wdat_top #(.FC_DIV_EXP(6), .FS_DIV_EXP(4), .RST_CYC(24)) DUT (
		.clk_sys_i, .arst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.lfclk_tick_i, .prescale_source_select_i(pss), .slow_mode_i(slow),
		.slow1_mode_i(slow1), .lowpower_hold_i(hold), .fetch_i,
		.watchdog_nmi_o(wnmi), .trap_nmi_o(tnmi), .internal_reset_o(irst),
		.hfosc_restart_o(hfr), .wdt_running_o(run), .bin_count_o(bcnt),
		.ram_trap_active_o(ram_act));

	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// ****
	// low clock ticks and pulse counters
	// ****
	always @(posedge clk_sys_i) begin
		lf <= lf + 2'h1;
		lfclk_tick_i <= lf == 2'h3;
	end
	always @(negedge clk_sys_i) begin
		ir_q <= irst;
		n_wn <= n_wn + 8'(wnmi);
		n_tn <= n_tn + 8'(tnmi);
		n_hf <= n_hf + 8'(hfr);
		n_ir <= n_ir + 8'(irst & ~ir_q);
	end
	// ****
	// tasks
	// ****
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic settle;
		@(negedge clk_sys_i);
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		tick(1);
		wr_i <= 1'b0;
	endtask
	task automatic fe(input logic [3:0] f);
		tick(1);
		fetch_i <= wdat_fetch_s'(f);
		tick(1);
		fetch_i <= '0;
		tick(3);
	endtask
	// clear, run n cycles, compare nmi and reset counts
	task automatic win(input int n, input logic [7:0] ew, input logic [7:0] er);
		logic [7:0] s1, s2;
		s1 = n_wn;
		s2 = n_ir;
		wr(WDAT_CODE_ADDR, WDAT_CODE_CLEAR);
		tick(n);
		chk(n_wn - s1, ew);
		chk(n_ir - s2, er);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ****
	// tests
	// ****
	initial begin
		tick(20);
		arst_n_i <= 1'b1;
		settle;
		chk(8'(run), 8'h01);
		chk(8'(bcnt), 8'h00);
		tick(1);
		rd_i <= 1'b1;
		addr_i <= WDAT_CTRL_ADDR;
		tick(1);
		rd_i <= 1'b0;
		#1 chk(rdata_o, WDAT_READ_VAL);
		repeat (4) win(150, 8'h00, 8'h00);
		win(300, 8'h00, 8'h01);
		wr(WDAT_CTRL_ADDR, 8'h38);
		win(300, 8'h01, 8'h00);
		wr(WDAT_CTRL_ADDR, 8'h39);
		win(300, 8'h01, 8'h00);
		pss <= 1'b1;
		win(300, 8'h01, 8'h00);
		pss <= 1'b0;
		slow <= 1'b1;
		win(300, 8'h01, 8'h00);
		slow <= 1'b0;
		wr(WDAT_CTRL_ADDR, 8'h3a);
		win(70, 8'h01, 8'h00);
		wr(WDAT_CTRL_ADDR, 8'h38);
		s = n_wn;
		wr(WDAT_CODE_ADDR, WDAT_CODE_CLEAR);
		tick(120);
		hold <= 1'b1;
		tick(600);
		hold <= 1'b0;
		tick(60);
		chk(n_wn - s, 8'h00);
		tick(100);
		chk(n_wn - s, 8'h01);
		wr(WDAT_CODE_ADDR, WDAT_CODE_DISABLE);
		settle;
		chk(8'(run), 8'h01);
		wr(WDAT_CODE_ADDR, WDAT_CODE_CLEAR);
		wr(WDAT_CTRL_ADDR, 8'h30);
		wr(WDAT_CODE_ADDR, 8'h55);
		settle;
		chk(8'(run), 8'h01);
		wr(WDAT_CODE_ADDR, WDAT_CODE_DISABLE);
		s = n_wn;
		tick(600);
		settle;
		chk(8'(run), 8'h00);
		chk(8'(bcnt), 8'h00);
		chk(n_wn - s, 8'h00);
		wr(WDAT_CTRL_ADDR, 8'h28);
		settle;
		chk(8'(run), 8'h01);
		wr(WDAT_CODE_ADDR, WDAT_CODE_CLEAR);
		s = n_tn;
		fe(4'ha);
		fe(4'h9);
		fe(4'hc);
		chk(n_tn - s, 8'h03);
		wr(WDAT_CTRL_ADDR, 8'h08);
		settle;
		chk(8'(ram_act), 8'h01);
		wr(WDAT_CODE_ADDR, WDAT_CODE_TRAPARM);
		fe(4'hc);
		chk(8'(ram_act), 8'h00);
		chk(n_tn - s, 8'h03);
		wr(WDAT_CTRL_ADDR, 8'h18);
		slow1 <= 1'b1;
		s = n_ir;
		fe(4'ha);
		tick(30);
		chk(n_ir - s, 8'h01);
		chk(n_hf, 8'h01);
		wr(WDAT_CTRL_ADDR, 8'h3c);
		win(20, 8'h01, 8'h00);
		s = n_wn;
		wr(WDAT_CODE_ADDR, WDAT_CODE_CLEAR);
		hold <= 1'b1;
		tick(100);
		hold <= 1'b0;
		wr(WDAT_CODE_ADDR, WDAT_CODE_CLEAR);
		chk(n_wn - s, 8'h00);
		tick(20);
		chk(n_wn - s, 8'h01);
		results;
	end
	initial begin
		tick(20000);
		n_fail++;
		results;
	end
endmodule

`default_nettype wire
